// file: hdl/arop_port.sv
/*
 Result output port of a sampling converter: parallel word, serial master
 with generated clock and frame sync, serial slave on an external clock with
 daisy chain and incomplete-read flag, and the busy indicator.
 Assumes a conversion core giving conv_start_in and conv_done_in pulses on
 clk_in, and a host that gates the slave serial clock with chip select.
*/
// Function
// R1: Master, read after convert: current result shifted only after conversion completes.
// R2: Slave: chain input appears on serial output 16 clock periods after read start.
// R3: Chain input is used only in serial slave mode.
// R4: Result held in shift register, sent most significant bit first.
// R5: Output format select picks straight binary or two's complement.
// R6: Master: each data bit stable across both generated clock edges.
// R7: Slave, no inversion: data changes on rising edge, host samples falling.
// R8: Slave, inversion: data changes on falling edge, host samples rising.
// R9: Serial clock pin driven in master mode, input in slave mode.
// R10: Master, sync not inverted: frame sync high while data valid.
// R11: Master, sync inverted: frame sync low while data valid.
// R12: Slave: unfinished read at conversion end drops data, pulses read error.
// R13: Top four parallel lines are outputs in every mode.
// R14: Parallel mode: bits 8 to 11 on the serial data, clock, sync, error lines.
// R15: Busy rises at conversion start, falls once result is loaded.
// R16: Host may treat busy falling edge as data ready; here the parallel lines show the new word one clk_in cycle after busy falls.
// R17: Slave: host supplies clock gated by chip select; data follows it.
// R18: Master, read during convert: previous result shifted during conversion.
// R19: Clock inversion select inverts serial clock in all serial modes.
// R20: Output drivers enabled only while chip select and read are low.
// R21: One 16-bit word per read, then chained bits in slave mode.
`include "arop_cfg.svh"
`default_nettype none

// ----------------------------------------------------------------
// Input filter
// ----------------------------------------------------------------
module arop_agree #(
   parameter int W = 1
) (
   // Synchroniser stages and filtered value
   input  wire logic [W-1:0] s2_in,
   input  wire logic [W-1:0] s3_in,
   input  wire logic [W-1:0] cur_in,
   // Next filtered value
   output logic      [W-1:0] next_out
);
   // One-cycle glitch in stage two never reaches the output
   always_comb begin
      next_out = cur_in;
      if (s2_in == s3_in) begin
         next_out = s3_in;
      end
   end
endmodule : arop_agree

module arop_port #(
   parameter int SCLK_DIV = `AROP_SCLK_DIV
) (
   // Clocks and reset
   input  wire logic                clk_in,
   input  wire logic                srst_in,
   input  wire logic                sclk_in,
   // Conversion core
   input  wire logic                conv_start_in,
   input  wire logic                conv_done_in,
   input  wire logic [15:0]         conv_result_in,
   // Mode pins
   input  wire arop_pkg::arop_mode_t mode_in,
   // Host strobes
   input  wire logic                cs_n_in,
   input  wire logic                rd_n_in,
   input  wire logic                chain_data_in,
   // Shared pins: bit 8 or serial data, bit 9 or clock, bit 10 or sync, bit 11 or error
   output logic                     serial_result_out,
   output logic                     sclk_out,
   output logic                     sclk_oe_out,
   output logic                     frame_sync_out,
   output logic                     incomplete_read_flag_out,
   // Parallel pins and status
   output logic [7:0]               par_low_out,
   output logic [3:0]               par_high_out,
   output logic                     data_oe_out,
   output logic                     busy_out
);

   // ----------------------------------------------------------------
   // Constants
   // ----------------------------------------------------------------
   localparam logic [`AROP_PHASE_BITS-1:0] PH_LAST = `AROP_PHASE_BITS'(SCLK_DIV - 1);
   localparam logic [`AROP_PHASE_BITS-1:0] PH_RISE = `AROP_PHASE_BITS'(SCLK_DIV / 4);
   localparam logic [`AROP_PHASE_BITS-1:0] PH_FALL = `AROP_PHASE_BITS'((3 * SCLK_DIV) / 4);

   arop_pkg::arop_core_t core;
   arop_pkg::arop_core_t next_core;
   arop_pkg::arop_link_t lnk;
   arop_pkg::arop_link_t next_lnk;
   logic                 sclk_eff;
   logic [`AROP_MSB:0]   fmt_word;
   logic                 rd_ok;
   logic                 ser;
   logic                 master;
   logic                 go;
   logic                 active;
   arop_pkg::arop_mode_t agree_mode;
   logic [1:0]           agree_ctl;
   logic [1:0]           agree_lnk;

   // ----------------------------------------------------------------
   // Input filters
   // ----------------------------------------------------------------
   arop_agree #(.W($bits(arop_pkg::arop_mode_t))) u_mode_agree (
      .s2_in    (core.mode_s2),
      .s3_in    (core.mode_s3),
      .cur_in   (core.mode),
      .next_out (agree_mode)
   );
   arop_agree #(.W(2)) u_ctl_agree (
      .s2_in    (core.ctl_s2),
      .s3_in    (core.ctl_s3),
      .cur_in   (core.ctl_n),
      .next_out (agree_ctl)
   );
   arop_agree #(.W(2)) u_lnk_agree (
      .s2_in    (core.lnk_s2),
      .s3_in    (core.lnk_s3),
      .cur_in   (core.lnk),
      .next_out (agree_lnk)
   );

   // ----------------------------------------------------------------
   // Format
   // ----------------------------------------------------------------
   // Core delivers straight binary; two's complement flips the top bit
   always_comb begin
      fmt_word = conv_result_in;
      if (!core.mode.output_format_select) begin
         fmt_word[`AROP_MSB] = ~conv_result_in[`AROP_MSB]; // R5
      end
   end

   // ----------------------------------------------------------------
   // Core domain
   // ----------------------------------------------------------------
   always_comb begin
      next_core = core;
      // Pins pass three flops; a change counts once stages two and three agree
      next_core.mode_s1 = mode_in;
      next_core.mode_s2 = core.mode_s1;
      next_core.mode_s3 = core.mode_s2;
      next_core.mode = agree_mode;
      next_core.ctl_s1 = {cs_n_in, rd_n_in};
      next_core.ctl_s2 = core.ctl_s1;
      next_core.ctl_s3 = core.ctl_s2;
      next_core.ctl_n = agree_ctl;
      next_core.lnk_s1 = {lnk.started, lnk.done};
      next_core.lnk_s2 = core.lnk_s1;
      next_core.lnk_s3 = core.lnk_s2;
      next_core.lnk = agree_lnk;

      ser    = core.mode.interface_select;
      master = ser && !core.mode.clock_source_select;
      rd_ok  = (core.ctl_n == 2'h0); // R20
      next_core.err = 1'b0;

      // Busy and result load
      if (conv_start_in) begin
         next_core.busy = 1'b1; // R15
      end
      if (conv_done_in) begin
         next_core.busy = 1'b0; // R15
         if (ser && core.mode.clock_source_select && !core.ctl_n[1] &&
             core.lnk[1] && !core.lnk[0]) begin
            next_core.err = 1'b1; // R12
         end else begin
            next_core.hold = fmt_word; // R4
            next_core.pend = master && !core.mode.read_during_convert_sel; // R1
         end
      end

      // Master shifter
      go = 1'b0;
      if (core.mst == arop_pkg::AROP_M_IDLE && master && rd_ok) begin
         if (core.mode.read_during_convert_sel) begin
            go = conv_start_in; // R18
         end else begin
            go = core.pend && !conv_done_in; // R1
         end
      end
      case (core.mst)
         arop_pkg::AROP_M_IDLE: begin
            if (go) begin
               next_core.mst   = arop_pkg::AROP_M_SHIFT;
               next_core.pend  = 1'b0;
               next_core.shift = core.hold; // R4
               next_core.bits  = '0;
               next_core.phase = '0;
            end
         end
         arop_pkg::AROP_M_SHIFT: begin
            next_core.phase = core.phase + 1'b1;
            if (core.phase == PH_LAST) begin
               next_core.phase = '0;
               next_core.shift = {core.shift[`AROP_MSB-1:0], 1'b0}; // R4
               next_core.bits  = core.bits + 1'b1;
               if (core.bits == `AROP_LAST_BIT) begin
                  next_core.mst = arop_pkg::AROP_M_IDLE; // R21
               end
            end
            if (!master) begin
               next_core.mst = arop_pkg::AROP_M_IDLE;
            end
         end
         default: begin
            next_core.mst = arop_pkg::AROP_M_IDLE;
         end
      endcase
      active = (next_core.mst == arop_pkg::AROP_M_SHIFT);

      // Pin drivers
      next_core.slave_ser = ser && core.mode.clock_source_select;
      next_core.data_oe   = rd_ok; // R20
      next_core.sclk_oe   = rd_ok && (!ser || master); // R9
      next_core.par_high  = core.hold[15:12]; // R13
      next_core.par_low   = ser ? 8'h00 : core.hold[7:0];
      if (!ser) begin
         next_core.d8  = core.hold[8]; // R14
         next_core.d9  = core.hold[9]; // R14
         next_core.d10 = core.hold[10]; // R14
         next_core.d11 = core.hold[11]; // R14
      end else if (master) begin
         // Data moves mid low phase of the uninverted clock, so it is stable over both edges
         next_core.d8  = active && next_core.shift[`AROP_MSB]; // R6
         next_core.d9  = (active && next_core.phase >= PH_RISE &&
                          next_core.phase < PH_FALL) ^ core.mode.clock_invert_sel; // R19
         next_core.d10 = active ^ core.mode.frame_polarity_sel; // R10 R11
         next_core.d11 = 1'b0;
      end else begin
         next_core.d8  = 1'b0;
         next_core.d9  = 1'b0;
         next_core.d10 = 1'b0;
         next_core.d11 = next_core.err; // R12
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         core          <= '0;
         core.ctl_s1   <= `AROP_RST_CTL_N;
         core.ctl_s2   <= `AROP_RST_CTL_N;
         core.ctl_s3   <= `AROP_RST_CTL_N;
         core.ctl_n    <= `AROP_RST_CTL_N;
         core.hold     <= `AROP_RST_WORD;
         core.mst      <= arop_pkg::AROP_M_IDLE;
      end else begin
         core <= next_core;
      end
   end

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------
   // Clock gated by chip select at the host; inversion by xor on the pin
   assign sclk_eff = sclk_in ^ mode_in.clock_invert_sel; // R19 R8

   // hold only changes while no slave read is seen, so it is quasi-static here
   always_comb begin
      next_lnk = lnk;
      if (!lnk.started) begin
         next_lnk.started = 1'b1;
         next_lnk.sdo     = core.hold[`AROP_MSB]; // R4
         next_lnk.shift   = {core.hold[`AROP_MSB-1:0], chain_data_in}; // R3
         next_lnk.bits    = 5'h01;
      end else begin
         next_lnk.sdo   = lnk.shift[`AROP_MSB];
         next_lnk.shift = {lnk.shift[`AROP_MSB-1:0], chain_data_in}; // R2
         if (lnk.bits != `AROP_FULL_BITS) begin
            next_lnk.bits = lnk.bits + 1'b1;
         end
         next_lnk.done = (next_lnk.bits == `AROP_FULL_BITS); // R21
      end
   end

   // The frame's own chip select ends it; the clock may stop afterwards
   always_ff @(posedge sclk_eff or posedge cs_n_in) begin
      if (cs_n_in) begin
         lnk <= '0; // R17
      end else begin
         lnk <= next_lnk; // R7 R8
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Slave data must come from the link flop; the pin is shared by mode
   assign serial_result_out        = core.slave_ser ? lnk.sdo : core.d8;
   assign sclk_out                 = core.d9;
   assign sclk_oe_out              = core.sclk_oe;
   assign frame_sync_out           = core.d10;
   assign incomplete_read_flag_out = core.d11;
   assign par_low_out              = core.par_low;
   assign par_high_out             = core.par_high;
   assign data_oe_out              = core.data_oe;
   assign busy_out                 = core.busy; // R16

endmodule : arop_port

`default_nettype wire

// file: inc/arop_cfg.svh
/*
 Constants of the converter result output port: word size, master clock
 divider, reset values. Assumes inclusion by bare name from the package and
 the design file.
*/
`ifndef AROP_CFG_SVH
`define AROP_CFG_SVH

// ----------------------------------------------------------------
// Word and frame
// ----------------------------------------------------------------
`define AROP_WORD_BITS     16
`define AROP_MSB           15
`define AROP_CNT_BITS      5
`define AROP_LAST_BIT      5'h0f
`define AROP_FULL_BITS     5'h10
// ----------------------------------------------------------------
// Master serial clock: clk_in cycles per period, multiple of four
// ----------------------------------------------------------------
`define AROP_SCLK_DIV      4
`define AROP_PHASE_BITS    8
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AROP_RST_WORD      16'h0000
`define AROP_RST_CTL_N     2'h3

`endif

// file: inc/arop_pkg.sv
/*
 Types of the converter result output port: synchronised mode pins,
 clock-domain state bundles, master shifter states. Assumes arop_cfg.svh on
 the include path.
*/
`include "arop_cfg.svh"
`default_nettype none

package arop_pkg;
   // ----------------------------------------------------------------
   // Mode pins
   // ----------------------------------------------------------------
   typedef struct packed {
      logic interface_select;
      logic clock_source_select;
      logic output_format_select;
      logic clock_invert_sel;
      logic frame_polarity_sel;
      logic read_during_convert_sel;
   } arop_mode_t;

   typedef enum logic {
      AROP_M_IDLE,
      AROP_M_SHIFT
   } arop_mst_t;

   // ----------------------------------------------------------------
   // Core clock domain state
   // ----------------------------------------------------------------
   typedef struct packed {
      arop_mode_t                    mode_s1;
      arop_mode_t                    mode_s2;
      arop_mode_t                    mode_s3;
      arop_mode_t                    mode;
      logic [1:0]                    ctl_s1;
      logic [1:0]                    ctl_s2;
      logic [1:0]                    ctl_s3;
      logic [1:0]                    ctl_n;
      logic [1:0]                    lnk_s1;
      logic [1:0]                    lnk_s2;
      logic [1:0]                    lnk_s3;
      logic [1:0]                    lnk;
      logic                          busy;
      logic [`AROP_MSB:0]            hold;
      logic                          err;
      logic                          pend;
      arop_mst_t                     mst;
      logic [`AROP_MSB:0]            shift;
      logic [`AROP_CNT_BITS-1:0]     bits;
      logic [`AROP_PHASE_BITS-1:0]   phase;
      logic                          slave_ser;
      logic                          d8;
      logic                          d9;
      logic                          d10;
      logic                          d11;
      logic                          data_oe;
      logic                          sclk_oe;
      logic [7:0]                    par_low;
      logic [3:0]                    par_high;
   } arop_core_t;

   // ----------------------------------------------------------------
   // Link clock domain state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                          started;
      logic                          done;
      logic [`AROP_CNT_BITS-1:0]     bits;
      logic [`AROP_MSB:0]            shift;
      logic                          sdo;
   } arop_link_t;
endpackage : arop_pkg

`default_nettype wire

// file: verif/arop_checker.sv
/*
 Checker of the result output port: busy timing, word lanes, master
 frames, read error. Assumes a bind to arop_port; mode pins move only when idle.
*/
`default_nettype none

module arop_checker #(
   parameter int SCLK_DIV = 4
) (
   // Inputs
   input wire logic                 clk_in,
   input wire logic                 srst_in,
   input wire logic                 conv_start_in,
   input wire logic                 conv_done_in,
   input wire logic [15:0]          conv_result_in,
   input wire arop_pkg::arop_mode_t mode_in,
   input wire logic                 cs_n_in,
   input wire logic                 rd_n_in,
   // Outputs
   input wire logic                 serial_result_out,
   input wire logic                 sclk_out,
   input wire logic                 sclk_oe_out,
   input wire logic                 frame_sync_out,
   input wire logic                 incomplete_read_flag_out,
   input wire logic [7:0]           par_low_out,
   input wire logic [3:0]           par_high_out,
   input wire logic                 data_oe_out,
   input wire logic                 busy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // --------
   // Helpers
   // --------
   localparam int FRAME = 16 * SCLK_DIV;
   arop_pkg::arop_mode_t prev;
   logic [15:0]          cnt;
   logic [3:0]           stab;
   wire                  ser = mode_in.interface_select;
   wire                  mst = ser && !mode_in.clock_source_select;
   wire                  act = frame_sync_out ^ mode_in.frame_polarity_sel;
   // Mode pins pass a synchroniser: judge only once settled
   wire                  calm = (stab == 4'hf);

   always_ff @(posedge clk_in) begin
      prev <= mode_in;
      cnt <= act ? cnt + 16'h0001 : 16'h0000;
      if (srst_in || prev != mode_in)
         stab <= 4'h0;
      else if (stab != 4'hf)
         stab <= stab + 4'h1;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // --------
   // Assertions
   // --------
   a_busy_start: assert property (conv_start_in |=> busy_out)
      else $error("busy not raised after start");
   a_busy_done: assert property (conv_done_in |=> !busy_out)
      else $error("busy not dropped after done");
   a_top_lanes: assert property (calm && conv_done_in ##1 !incomplete_read_flag_out |=>
      par_high_out == ($past(conv_result_in[15:12], 2) ^ {!mode_in.output_format_select, 3'h0}))
      else $error("top lanes wrong");
   a_par_lanes: assert property (calm && !ser && conv_done_in |-> ##2 {incomplete_read_flag_out,
      frame_sync_out, sclk_out, serial_result_out, par_low_out} == $past(conv_result_in[11:0], 2))
      else $error("parallel lanes wrong");
   a_oe_on: assert property ((!cs_n_in && !rd_n_in) [*7] |-> data_oe_out)
      else $error("drivers off while strobed");
   a_oe_off: assert property ((cs_n_in || rd_n_in) [*7] |-> !data_oe_out)
      else $error("drivers on while not strobed");
   a_slave_pin: assert property (calm && ser && mode_in.clock_source_select |-> !sclk_oe_out)
      else $error("clock pin driven in slave mode");
   a_master_pin: assert property (calm && mst && $rose(act) |-> sclk_oe_out)
      else $error("clock pin not driven in master frame");
   a_frame_len: assert property (calm && mst && $fell(act) |-> cnt == FRAME)
      else $error("frame sync length wrong");
   a_bit_steady: assert property (calm && mst && act && $past(act) && $changed(sclk_out)
      |-> $stable(serial_result_out))
      else $error("data moved on a clock edge");
   a_after_conv: assert property (calm && mst && !mode_in.read_during_convert_sel
      && $rose(act) |-> !busy_out)
      else $error("frame began during conversion");
   a_err_pulse: assert property (calm && ser && incomplete_read_flag_out
      |-> $past(conv_done_in) ##1 !incomplete_read_flag_out)
      else $error("read error pulse wrong");

   c_par: cover property (calm && !ser && conv_done_in);
   c_frame: cover property (calm && mst && $fell(act));
   c_err: cover property (calm && ser && incomplete_read_flag_out);
endmodule : arop_checker

`default_nettype wire

// file: verif/arop_host.sv
/*
 Host model: strobes, slave serial clock within frames, chain source,
 capture of serial words. Assumes the result port's pins by name.
*/
`default_nettype none

module arop_host (
   // Pins
   input  wire logic clk_in,
   input  wire logic serial_result_out,
   input  wire logic sclk_out,
   output logic      sclk_in,
   output logic      cs_n_in,
   output logic      rd_n_in,
   output logic      chain_data_in
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      sclk_in = 1'b0;
      cs_n_in = 1'b1;
      rd_n_in = 1'b1;
      chain_data_in = 1'b0;
   end

   task automatic strobe(input logic v);
      @(posedge clk_in);
      cs_n_in <= v;
      rd_n_in <= v;
   endtask : strobe

   // Clock idles at inv, so it stands still outside frames
   task automatic slave_read(input logic inv, input int n, input logic [7:0] ch,
                             input logic keep, output logic [23:0] w);
      w = 24'h000000;
      sclk_in = inv;
      chain_data_in = ch[7];
      strobe(1'b0);
      repeat (8) @(posedge clk_in);
      for (int i = 0; i < n; i++) begin
         #32 sclk_in = !inv;
         #32 sclk_in = inv;
         w = {w[22:0], serial_result_out};
         chain_data_in = (i < 7) ? ch[6 - i] : !chain_data_in;
      end
      if (!keep)
         strobe(1'b1);
   endtask : slave_read

   task automatic master_read(input logic inv, output logic [15:0] w);
      strobe(1'b0);
      for (int i = 0; i < 16; i++) begin
         do @(sclk_out); while (sclk_out !== !inv);
         w = {w[14:0], serial_result_out};
         chain_data_in = !chain_data_in;
      end
      // Let the frame close before dropping the strobes
      repeat (4) @(posedge clk_in);
      strobe(1'b1);
   endtask : master_read
endmodule : arop_host

`default_nettype wire

// file: verif/test_adc_result_output_port.sv
/*
 Testbench of the result output port against a word model.
 Assumes arop_pkg, arop_port, arop_host and arop_checker compiled first.
*/
`default_nettype none

module test_adc_result_output_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk_in, srst_in, sclk_in, conv_start_in, conv_done_in;
   logic [15:0]          conv_result_in, hold, e, w16;
   logic [23:0]          w24;
   logic [7:0]           ch, par_low_out;
   logic [3:0]           par_high_out;
   arop_pkg::arop_mode_t mode_in;
   logic                 cs_n_in, rd_n_in, chain_data_in, serial_result_out, sclk_out;
   logic                 sclk_oe_out, frame_sync_out, incomplete_read_flag_out;
   logic                 data_oe_out, busy_out;
   int                   err_count, check_count, cycles, flag_count, flag_base, seed = 62;

   arop_port #(.SCLK_DIV(4)) uut (.clk_in, .srst_in, .sclk_in, .conv_start_in,
      .conv_done_in, .conv_result_in, .mode_in, .cs_n_in, .rd_n_in, .chain_data_in,
      .serial_result_out, .sclk_out, .sclk_oe_out, .frame_sync_out,
      .incomplete_read_flag_out, .par_low_out, .par_high_out, .data_oe_out, .busy_out);
   arop_host host (.clk_in, .serial_result_out, .sclk_out, .sclk_in, .cs_n_in,
      .rd_n_in, .chain_data_in);

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      cycles++;
      if (incomplete_read_flag_out)
         flag_count++;
      if (cycles == 8000) begin
         err_count++;
         end_of_test();
      end
   end

   task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic end_of_test;
      $display("Mismatches %0d in %0d checks", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // Model keeps the held word; a refused result leaves it alone
   task automatic conv(input int len, input logic drop);
      logic [15:0] r;
      r = 16'($random(seed));
      @(posedge clk_in);
      conv_start_in <= 1'b1;
      @(posedge clk_in);
      conv_start_in <= 1'b0;
      repeat (len) @(posedge clk_in);
      conv_done_in <= 1'b1;
      conv_result_in <= r;
      @(posedge clk_in);
      conv_done_in <= 1'b0;
      conv_result_in <= ~r;
      if (!drop)
         hold = r ^ {!mode_in.output_format_select, 15'h0000};
      repeat (3) @(posedge clk_in);
      check("busy", 24'h0, busy_out);
   endtask : conv

   task automatic set_mode(input logic [5:0] m);
      @(posedge clk_in);
      mode_in <= arop_pkg::arop_mode_t'(m);
      repeat (20) @(posedge clk_in);
   endtask : set_mode

   initial begin
      srst_in = 1'b1;
      conv_start_in = 1'b0;
      conv_done_in = 1'b0;
      conv_result_in = 16'h0000;
      mode_in = arop_pkg::arop_mode_t'(6'h00);
      repeat (5) @(posedge clk_in);
      srst_in <= 1'b0;
      for (int f = 0; f < 2; f++) begin
         set_mode({2'b00, f[0], 3'b000});
         host.strobe(1'b0);
         repeat (3) begin
            conv(10, 1'b0);
            check("parallel", hold, {par_high_out, incomplete_read_flag_out, frame_sync_out,
               sclk_out, serial_result_out, par_low_out});
         end
         check("drivers", 24'h1, data_oe_out);
         host.strobe(1'b1);
      end
      for (int k = 0; k < 4; k++) begin
         set_mode({3'b101, k[0], k[1], 1'b0});
         conv(20, 1'b0);
         host.master_read(k[0], w16);
         check("master", hold, w16);
      end
      set_mode(6'h29);
      e = hold;
      fork
         host.master_read(1'b0, w16);
         begin
            repeat (8) @(posedge clk_in);
            conv(80, 1'b0);
         end
      join
      check("during convert", e, w16);
      for (int k = 0; k < 2; k++) begin
         set_mode({3'b111, k[0], 2'b00});
         conv(10, 1'b0);
         ch = 8'($random(seed));
         host.slave_read(k[0], 24, ch, 1'b0, w24);
         check("slave chain", {hold, ch}, w24);
      end
      e = hold;
      flag_base = flag_count;
      // Mode still has clock inversion on, so the host must idle its clock high
      host.slave_read(1'b1, 5, ch, 1'b1, w24);
      conv(10, 1'b1);
      host.strobe(1'b1);
      check("read error", 24'h1, 24'(flag_count - flag_base));
      host.slave_read(1'b1, 16, ch, 1'b0, w24);
      check("kept word", e, w24[15:0]);
      end_of_test();
   end
endmodule : test_adc_result_output_port

bind arop_port arop_checker #(.SCLK_DIV(SCLK_DIV)) chk (.clk_in, .srst_in, .conv_start_in,
   .conv_done_in, .conv_result_in, .mode_in, .cs_n_in, .rd_n_in, .serial_result_out,
   .sclk_out, .sclk_oe_out, .frame_sync_out, .incomplete_read_flag_out, .par_low_out,
   .par_high_out, .data_oe_out, .busy_out);

`default_nettype wire
